// *** rtl/scsst_pkg.sv ***
// Shared constants for the SPI chip-select, status and transmit block.
// Assumes a single system clock; no imports, users write scsst_pkg::name.
package scsst_pkg;

  // ----------------------------------------------------------------
  // Register indices on the system bus
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL0 = 4'h0; // control_reg_0
  localparam logic [3:0] REG_CTRL1 = 4'h1; // control_reg_1
  localparam logic [3:0] REG_CTRL2 = 4'h2; // control_reg_2
  localparam logic [3:0] REG_CSEL = 4'h3; // slave_select_lines
  localparam logic [3:0] REG_STATUS = 4'h4; // port_status_flags
  localparam logic [3:0] REG_TXD = 4'h5; // transmit_byte
  localparam logic [3:0] REG_RXD = 4'h6; // receive_byte

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CR2_MASTER_EN = 7; // master_enable
  localparam int CR2_CPOL = 2; // Clock polarity
  localparam int CR2_CPHA = 1; // Clock phase
  localparam int CR2_LSB_FIRST = 0; // lsb_first
  localparam int ST_ACTIVE = 7; // transfer_active
  localparam int ST_BUSY = 6; // Sequence busy
  localparam int ST_TX_READY = 4; // tx_ready_flag
  localparam int ST_RX_READY = 3; // rx_ready_flag
  localparam int ST_TX_OVERRUN = 2; // tx_overrun_flag
  localparam int ST_RX_OVERRUN = 1; // rx_overrun_flag
  localparam int ST_MODE_FAULT = 0; // mode_fault_flag
  localparam int CSEL_BITS = 4; // Select lines held

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CSEL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hFF; // Sent by a slave when nothing is queued
  localparam int SCK_HALF_CYC = 8; // System cycles per half serial clock
  localparam int BYTE_BITS = 8;
  localparam int TX_FIFO_DEPTH = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_LAST = 3'b100
  } scsst_state_t;

endpackage : scsst_pkg

// *** rtl/scsst_fifo_if.sv ***
// Valid/ready carrier between the transmit queue and the shift engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface scsst_fifo_if #(
  parameter int WIDTH = 8
);
  logic inValid; // Producer offers a word
  logic inReady; // Queue can take a word
  logic [WIDTH-1:0] inData;
  logic outValid; // Queue holds a word
  logic outReady; // Consumer takes the word
  logic [WIDTH-1:0] outData;

  modport fifo (input inValid, inData, outReady, output inReady, outValid, outData);
  modport user (output inValid, inData, outReady, input inReady, outValid, outData);
endinterface : scsst_fifo_if

// *** rtl/scsst_fifo.sv ***
// Small synchronous FIFO holding queued transmit bytes.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module scsst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Queue ports
  scsst_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wrPtr_r; // Next write slot
  logic [AW-1:0] rdPtr_r; // Oldest word
  logic [AW:0] count_r; // Words held
  logic push;
  logic pop;

  // Honest flags from the count
  assign q.inReady = (count_r != (AW+1)'(DEPTH));
  assign q.outValid = (count_r != '0);
  assign q.outData = mem[rdPtr_r];
  assign push = q.inValid && q.inReady;
  assign pop = q.outValid && q.outReady;

  // ------------------------------------------------------------
  // Storage write, no reset needed for data
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= q.inData;
    end
  end

  // ------------------------------------------------------------
  // Pointers and occupancy
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      // Simultaneous push and pop keep the count
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : scsst_fifo

// *** rtl/scsst_top.sv ***
// SPI port: chip-select register, status flags, transmit queue and
// a compact master/slave byte shifter behind a simple system bus.
// Assumes the bus master holds each strobe for one mclk cycle; serial
// pins are asynchronous and are synchronised here.
//
// What this block does
// - Four active-low selects follow select register bits in master mode
// - Select 0 dedicated pin, 1-3 routable outputs
// - Select register write also resets serial core
// - Transmit ready while empty, cleared by write
// - Receive ready while byte held, cleared by read
// - Transmit overrun flag set once detected
// - Receive overrun when unread byte is replaced
// - Mode fault on select low in master
// - Any control register write clears mode fault
// - Five status flags can request interrupts
// - Transmit byte order follows lsb-first setting
// - Select register readable, upper bits read zero
// - Lsb-first zero sends msb first
`timescale 1ns/1ps
module scsst_top #(
  parameter int SCK_HALF = scsst_pkg::SCK_HALF_CYC,
  parameter int TX_DEPTH = scsst_pkg::TX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // System bus
  input wire logic [3:0] sbAddr,
  input wire logic sbWrEn,
  input wire logic sbRdEn,
  input wire logic [7:0] sbWrData,
  output logic [7:0] sbRdData,
  output logic sbRdValid,
  // Serial clock pin
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  // Serial data pins
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  // Select pins
  input wire logic slaveSelIn,
  output logic selectLine0,
  output logic [2:0] selectLines13,
  // Interrupt requests per status flag
  output logic [4:0] intReq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wrCtrl0;
  logic wrCtrl1;
  logic wrCtrl2;
  logic wrCsel;
  logic wrTxd;
  logic rdRxd;
  logic coreRst; // Reset of the serial engine and queue

  assign wrCtrl0 = sbWrEn && (sbAddr == scsst_pkg::REG_CTRL0);
  assign wrCtrl1 = sbWrEn && (sbAddr == scsst_pkg::REG_CTRL1);
  assign wrCtrl2 = sbWrEn && (sbAddr == scsst_pkg::REG_CTRL2);
  assign wrCsel = sbWrEn && (sbAddr == scsst_pkg::REG_CSEL);
  assign wrTxd = sbWrEn && (sbAddr == scsst_pkg::REG_TXD);
  assign rdRxd = sbRdEn && (sbAddr == scsst_pkg::REG_RXD);
  assign coreRst = rst || wrCsel;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl0_r; // Stored only, write clears fault
  logic [7:0] ctrl1_r; // Stored only, write clears fault
  logic [7:0] ctrl2_r; // Mode bits
  logic [3:0] csel_r; // Select pattern
  logic masterEn;
  logic cpol;
  logic cpha;
  logic lsbFirst;

  assign masterEn = ctrl2_r[scsst_pkg::CR2_MASTER_EN];
  assign cpol = ctrl2_r[scsst_pkg::CR2_CPOL];
  assign cpha = ctrl2_r[scsst_pkg::CR2_CPHA];
  assign lsbFirst = ctrl2_r[scsst_pkg::CR2_LSB_FIRST];

  // Control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl0_r <= scsst_pkg::CTRL_RESET;
      ctrl1_r <= scsst_pkg::CTRL_RESET;
      ctrl2_r <= scsst_pkg::CTRL_RESET;
    end else begin
      if (wrCtrl0) begin
        ctrl0_r <= sbWrData;
      end
      if (wrCtrl1) begin
        ctrl1_r <= sbWrData;
      end
      if (wrCtrl2) begin
        ctrl2_r <= sbWrData;
      end
    end
  end

  // Select register; only the low four bits are storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      csel_r <= scsst_pkg::CSEL_RESET[3:0];
    end else if (wrCsel) begin
      csel_r <= sbWrData[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, a change counts when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] sckSync_r;
  logic [2:0] mosiSync_r;
  logic [2:0] misoSync_r;
  logic [2:0] ssSync_r;
  logic sckStable_r; // Filtered serial clock
  logic mosiStable_r;
  logic misoStable_r;
  logic ssStable_r; // Filtered select, low = selected

  always_ff @(posedge mclk) begin
    if (rst) begin
      sckSync_r <= 3'h0;
      mosiSync_r <= 3'h0;
      misoSync_r <= 3'h0;
      ssSync_r <= 3'h7;
    end else begin
      sckSync_r <= {sckSync_r[1:0], sckIn};
      mosiSync_r <= {mosiSync_r[1:0], mosiIn};
      misoSync_r <= {misoSync_r[1:0], misoIn};
      ssSync_r <= {ssSync_r[1:0], slaveSelIn};
    end
  end

  // Accept a level only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      sckStable_r <= 1'b0;
      mosiStable_r <= 1'b0;
      misoStable_r <= 1'b0;
      ssStable_r <= 1'b1;
    end else begin
      if (sckSync_r[1] == sckSync_r[2]) begin
        sckStable_r <= sckSync_r[2];
      end
      if (mosiSync_r[1] == mosiSync_r[2]) begin
        mosiStable_r <= mosiSync_r[2];
      end
      if (misoSync_r[1] == misoSync_r[2]) begin
        misoStable_r <= misoSync_r[2];
      end
      if (ssSync_r[1] == ssSync_r[2]) begin
        ssStable_r <= ssSync_r[2];
      end
    end
  end

  // Edge detection on the filtered clock
  logic sckPrev_r;
  logic ssPrev_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sckPrev_r <= 1'b0;
      ssPrev_r <= 1'b1;
    end else begin
      sckPrev_r <= sckStable_r;
      ssPrev_r <= ssStable_r;
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  scsst_fifo_if #(.WIDTH(scsst_pkg::BYTE_BITS)) txq ();

  scsst_fifo #(
    .WIDTH(scsst_pkg::BYTE_BITS),
    .DEPTH(TX_DEPTH)
  ) i_scsst_fifo (
    .mclk(mclk),
    .rst(coreRst),
    .q(txq.fifo)
  );

  // Host writes feed the queue; a full queue refuses the byte
  assign txq.inValid = wrTxd;
  assign txq.inData = sbWrData;

  // ----------------------------------------------------------------
  // Serial event generation
  // ----------------------------------------------------------------
  scsst_pkg::scsst_state_t state_r;
  logic [$clog2(SCK_HALF)-1:0] divCnt_r; // Half-period divider
  logic halfTick; // One-cycle enable per half period
  logic phase_r; // Master clock is in its active half
  logic slaveActive;
  logic sckLead;
  logic sckTrail;
  logic sampleEv;
  logic driveEv;
  logic sdiBit;

  assign halfTick = masterEn && (state_r != scsst_pkg::ST_IDLE) &&
                    (divCnt_r == ($clog2(SCK_HALF))'(SCK_HALF - 1));
  assign slaveActive = !masterEn && !ssStable_r;
  // Leading edge moves the clock away from its idle level
  always_comb begin
    if (masterEn) begin
      sckLead = halfTick && !phase_r;
      sckTrail = halfTick && phase_r;
    end else begin
      sckLead = slaveActive && (sckStable_r != sckPrev_r) && (sckStable_r != cpol);
      sckTrail = slaveActive && (sckStable_r != sckPrev_r) && (sckStable_r == cpol);
    end
  end
  assign sampleEv = cpha ? sckTrail : sckLead;
  assign driveEv = cpha ? sckLead : sckTrail;
  assign sdiBit = masterEn ? misoStable_r : mosiStable_r;

  // Divider runs whenever the engine is not idle, in either mode
  always_ff @(posedge mclk) begin
    if (coreRst || state_r == scsst_pkg::ST_IDLE || halfTick) begin
      divCnt_r <= '0;
    end else begin
      divCnt_r <= divCnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  logic [7:0] txShift_r;
  logic [7:0] rxShift_r;
  logic [7:0] rxShift_nxt;
  logic [2:0] bitCnt_r;
  logic firstDrive_r; // Skip the shift on the first drive edge
  logic masterStart;
  logic slaveStart;
  logic slaveReload;
  logic loadByte;
  logic byteDone;
  logic [7:0] nextTx;

  assign masterStart = masterEn && (state_r == scsst_pkg::ST_IDLE) && txq.outValid;
  assign slaveStart = slaveActive && ssPrev_r && (state_r == scsst_pkg::ST_IDLE);
  assign slaveReload = !masterEn && (state_r == scsst_pkg::ST_SHIFT) && driveEv &&
                       !firstDrive_r && (bitCnt_r == 3'h0);
  assign loadByte = masterStart || slaveStart || slaveReload;
  assign txq.outReady = loadByte; // Pop only when the shifter takes a byte
  // Empty queue in slave mode sends an idle byte
  assign nextTx = txq.outValid ? txq.outData : scsst_pkg::TX_IDLE_BYTE;
  assign byteDone = sampleEv && (state_r == scsst_pkg::ST_SHIFT) &&
                    (bitCnt_r == scsst_pkg::LAST_BIT);
  // Received bit enters from the side matching the wire order
  assign rxShift_nxt = lsbFirst ? {sdiBit, rxShift_r[7:1]} : {rxShift_r[6:0], sdiBit};

  // Engine state
  always_ff @(posedge mclk) begin
    if (coreRst) begin
      state_r <= scsst_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        scsst_pkg::ST_IDLE: begin
          if (masterStart || slaveStart) begin
            state_r <= scsst_pkg::ST_SHIFT;
          end
        end
        scsst_pkg::ST_SHIFT: begin
          if (!masterEn && ssStable_r) begin
            // Deselect ends a slave sequence at once
            state_r <= scsst_pkg::ST_IDLE;
          end else if (masterEn && byteDone) begin
            // Phase 1 samples on the closing edge, so the byte is done
            state_r <= cpha ? scsst_pkg::ST_IDLE : scsst_pkg::ST_LAST;
          end
        end
        scsst_pkg::ST_LAST: begin
          // Wait for the closing clock edge before the next byte
          if (sckTrail) begin
            state_r <= scsst_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Master clock phase
  always_ff @(posedge mclk) begin
    if (coreRst || state_r == scsst_pkg::ST_IDLE) begin
      phase_r <= 1'b0;
    end else if (halfTick) begin
      phase_r <= !phase_r;
    end
  end

  // Transmit shifter
  always_ff @(posedge mclk) begin
    if (coreRst) begin
      txShift_r <= scsst_pkg::TX_IDLE_BYTE;
      firstDrive_r <= 1'b0;
    end else if (loadByte) begin
      txShift_r <= nextTx;
      firstDrive_r <= cpha && !slaveReload;
    end else if (driveEv && state_r == scsst_pkg::ST_SHIFT) begin
      if (firstDrive_r) begin
        firstDrive_r <= 1'b0;
      end else if (bitCnt_r != 3'h0) begin
        // Shift toward the bit that leaves next
        txShift_r <= lsbFirst ? {1'b1, txShift_r[7:1]} : {txShift_r[6:0], 1'b1};
      end
    end
  end

  // Receive shifter and bit count
  always_ff @(posedge mclk) begin
    if (coreRst || masterStart || slaveStart) begin
      rxShift_r <= 8'h00;
      bitCnt_r <= 3'h0;
    end else if (sampleEv && state_r == scsst_pkg::ST_SHIFT) begin
      rxShift_r <= rxShift_nxt;
      bitCnt_r <= bitCnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive register and status flags
  // ----------------------------------------------------------------
  logic [7:0] rxData_r;
  logic rxReady_r;
  logic rxOverrun_r;
  logic txOverrun_r;
  logic modeFault_r;
  logic txReady;
  logic xferActive;
  logic busy;
  logic [7:0] status;

  // Captured byte replaces any unread one
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxData_r <= 8'h00;
    end else if (byteDone) begin
      rxData_r <= rxShift_nxt;
    end
  end

  // Sticky flags; a setting event wins over its clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxReady_r <= 1'b0;
      rxOverrun_r <= 1'b0;
      txOverrun_r <= 1'b0;
      modeFault_r <= 1'b0;
    end else begin
      if (byteDone) begin
        rxReady_r <= 1'b1;
      end else if (rdRxd) begin
        rxReady_r <= 1'b0;
      end
      if (byteDone && rxReady_r && !rdRxd) begin
        rxOverrun_r <= 1'b1;
      end
      // Byte refused by a full queue is a transmit overrun
      if (wrTxd && !txq.inReady) begin
        txOverrun_r <= 1'b1;
      end else if (wrCsel) begin
        txOverrun_r <= 1'b0;
      end
      if (masterEn && !ssStable_r) begin
        modeFault_r <= 1'b1;
      end else if (wrCtrl0 || wrCtrl1 || wrCtrl2) begin
        modeFault_r <= 1'b0;
      end
    end
  end

  // Empty queue means the transmit register is free
  assign txReady = !txq.outValid;
  assign xferActive = (state_r != scsst_pkg::ST_IDLE);
  assign busy = xferActive || (masterEn ? txq.outValid : !ssStable_r);
  always_comb begin
    status = 8'h00;
    status[scsst_pkg::ST_ACTIVE] = xferActive;
    status[scsst_pkg::ST_BUSY] = busy;
    status[scsst_pkg::ST_TX_READY] = txReady;
    status[scsst_pkg::ST_RX_READY] = rxReady_r;
    status[scsst_pkg::ST_TX_OVERRUN] = txOverrun_r;
    status[scsst_pkg::ST_RX_OVERRUN] = rxOverrun_r;
    status[scsst_pkg::ST_MODE_FAULT] = modeFault_r;
  end

  // ----------------------------------------------------------------
  // Read path: registered data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sbRdData <= 8'h00;
      sbRdValid <= 1'b0;
    end else begin
      sbRdValid <= sbRdEn;
      if (sbRdEn) begin
        unique case (sbAddr)
          scsst_pkg::REG_CTRL0: sbRdData <= ctrl0_r;
          scsst_pkg::REG_CTRL1: sbRdData <= ctrl1_r;
          scsst_pkg::REG_CTRL2: sbRdData <= ctrl2_r;
          scsst_pkg::REG_CSEL: sbRdData <= {4'h0, csel_r};
          scsst_pkg::REG_STATUS: sbRdData <= status;
          scsst_pkg::REG_RXD: sbRdData <= rxData_r;
          // Transmit register is write-only; unmapped reads give zero
          default: sbRdData <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------
  logic txBit;
  // Bit 0 leaves first only with lsb-first set
  assign txBit = lsbFirst ? txShift_r[0] : txShift_r[7];

  always_ff @(posedge mclk) begin
    if (rst) begin
      sckOut <= 1'b0;
      sckOe <= 1'b0;
      mosiOut <= 1'b1;
      mosiOe <= 1'b0;
      misoOut <= 1'b1;
      misoOe <= 1'b0;
    end else begin
      // Master owns clock and data-out; idle clock sits at polarity level
      sckOut <= cpol ^ phase_r;
      sckOe <= masterEn;
      mosiOut <= txBit;
      mosiOe <= masterEn;
      // Slave answers only while selected; host must queue early
      misoOut <= txBit;
      misoOe <= slaveActive;
    end
  end

  // Selects follow the register in master mode, otherwise released high
  always_ff @(posedge mclk) begin
    if (rst) begin
      selectLine0 <= 1'b1;
      selectLines13 <= 3'h7;
    end else begin
      selectLine0 <= masterEn ? csel_r[0] : 1'b1;
      selectLines13 <= masterEn ? csel_r[3:1] : 3'h7;
    end
  end

  // Interrupt request levels mirror the flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      intReq <= 5'h00;
    end else begin
      intReq <= {txReady, rxReady_r, txOverrun_r, rxOverrun_r, modeFault_r};
    end
  end

endmodule : scsst_top

// *** test/scsst_props.sv ***
// Checker on the ports of the SPI select/status block.
// Bound to scsst_top; sees only its ports.
`timescale 1ns/1ps
module scsst_props (
  // Clock and bus
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] sbAddr,
  input wire logic sbWrEn,
  input wire logic sbRdEn,
  input wire logic [7:0] sbWrData,
  input wire logic sbRdValid,
  // Pins and flags
  input wire logic sckOe,
  input wire logic slaveSelIn,
  input wire logic selectLine0,
  input wire logic [2:0] selectLines13,
  input wire logic [4:0] intReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rdv; sbRdEn |=> sbRdValid; endproperty
  a_rdv: assert property (p_rdv) else $error("read not answered");
  property p_sel; sbWrEn && sbAddr == 4'h3 && sckOe
    |-> ##3 {selectLines13, selectLine0} == $past(sbWrData[3:0], 3); endproperty
  a_sel: assert property (p_sel) else $error("select lines wrong");
  property p_slv; !sckOe [*3] |-> selectLine0 && selectLines13 == 3'h7; endproperty
  a_slv: assert property (p_slv) else $error("select driven in slave");
  property p_toe; sbWrEn && sbAddr == 4'h3 |-> ##[1:3] !intReq[2]; endproperty
  a_toe: assert property (p_toe) else $error("overrun kept");
  property p_tx_ready_flag; sbWrEn && sbAddr == 4'h5 && !sckOe && slaveSelIn
    |-> ##[1:3] !intReq[4]; endproperty
  a_tx_ready_flag: assert property (p_tx_ready_flag) else $error("tx ready kept");
  property p_rx_ready_flag; sbRdEn && sbAddr == 4'h6 |-> ##[1:3] !intReq[3]; endproperty
  a_rx_ready_flag: assert property (p_rx_ready_flag) else $error("rx ready kept");
  property p_mdf; $fell(slaveSelIn) && sckOe |-> ##[1:8] intReq[0]; endproperty
  a_mdf: assert property (p_mdf) else $error("no mode fault");
  property p_mclr; slaveSelIn [*8] ##0 (sbWrEn && sbAddr < 4'h3)
    |-> ##[1:3] !intReq[0]; endproperty
  a_mclr: assert property (p_mclr) else $error("mode fault kept");
  c_ovr: cover property (intReq[2]);
  c_roe: cover property (intReq[1]);
  c_mdf: cover property (intReq[0]);
endmodule : scsst_props

// *** test/scsst_slave_model.sv ***
// SPI slave on select line 0, clock mode 0 only.
// Bench sets the reply byte; received bits shift in msb-first.
`timescale 1ns/1ps
module scsst_slave_model (
  input wire logic sck,
  input wire logic selN,
  input wire logic mosi,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] sh = 8'hFF; // Reply shifter
  logic [2:0] cnt = 3'h0; // Bits seen in byte
  initial miso = 1'b1;
  initial rxByte = 8'h00;
  // Load reply on select
  always @(negedge selN) begin
    sh = txByte;
    miso = txByte[7];
  end
  // Released line shows the inverse, never a stale bit
  always @(posedge selN) miso = ~miso;
  // Sample on rising clock
  always @(posedge sck) if (!selN) begin
    rxByte = {rxByte[6:0], mosi};
    cnt = cnt + 3'h1;
  end
  // Shift on falling clock, reload at byte end
  always @(negedge sck) if (!selN) begin
    sh = (cnt == 3'h0) ? txByte : {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule : scsst_slave_model

// *** test/scsst_top_test.sv ***
// Bench for scsst_top: bus tasks, slave model, bench as external master.
// Assumes the design files are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %0h", $time, g); end end
bind scsst_top scsst_props i_scsst_props (.mclk(mclk), .rst(rst), .sbAddr(sbAddr),
  .sbWrEn(sbWrEn), .sbRdEn(sbRdEn), .sbWrData(sbWrData), .sbRdValid(sbRdValid),
  .sckOe(sckOe), .slaveSelIn(slaveSelIn), .selectLine0(selectLine0),
  .selectLines13(selectLines13), .intReq(intReq));
module scsst_top_test;
  logic mclk = 0, rst = 1, sbWrEn = 0, sbRdEn = 0, sckIn = 0, mosiIn = 1, slaveSelIn = 1;
  logic [3:0] sbAddr = 4'h0;
  logic [7:0] sbWrData = 8'h00, sr, mTx = 8'h3C, sbRdData, mRx;
  logic sbRdValid, sckOut, sckOe, mosiOut, mosiOe, misoIn, misoOut, misoOe, selectLine0;
  logic [2:0] selectLines13;
  logic [4:0] intReq;
  int fail_count = 0, num_checks = 0;
  always #2.5 mclk = ~mclk;
  scsst_top i_scsst_top (.mclk(mclk), .rst(rst), .sbAddr(sbAddr), .sbWrEn(sbWrEn),
    .sbRdEn(sbRdEn), .sbWrData(sbWrData), .sbRdData(sbRdData), .sbRdValid(sbRdValid),
    .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn), .mosiOut(mosiOut),
    .mosiOe(mosiOe), .misoIn(misoIn), .misoOut(misoOut), .misoOe(misoOe),
    .slaveSelIn(slaveSelIn), .selectLine0(selectLine0), .selectLines13(selectLines13),
    .intReq(intReq));
  scsst_slave_model i_scsst_slave_model (.sck(sckOut), .selN(selectLine0), .mosi(mosiOut),
    .txByte(mTx), .miso(misoIn), .rxByte(mRx));
  task report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // One-cycle write strobe, driven on the falling edge
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    {sbAddr, sbWrData, sbWrEn} = {a, d, 1'b1};
    @(negedge mclk);
    sbWrEn = 0;
  endtask : wr
  // Read, mask and compare
  task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge mclk);
    {sbAddr, sbRdEn} = {a, 1'b1};
    @(negedge mclk);
    sbRdEn = 0;
    for (int i = 0; i < 4 && sbRdValid !== 1'b1; i++) @(negedge mclk);
    if (sbRdValid !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    `CHK(sbRdData & m, e)
  endtask : rc
  // Bounded wait for a flag
  task waitq(input int b);
    for (int i = 0; i < 4000; i++) begin
      if (intReq[b] === 1'b1) return;
      @(negedge mclk);
    end
    fail_count++;
    report_and_stop();
  endtask : waitq
  // External master byte, 125 ns serial period, clock still outside
  task sbyte(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosiIn = t[i];
      repeat (12) @(negedge mclk);
      sckIn = 1;
      r[i] = misoOut;
      repeat (13) @(negedge mclk);
      sckIn = 0;
    end
  endtask : sbyte
  initial begin
    repeat (16) @(negedge mclk);
    rst = 0;
    rc(4'h3, 8'hFF, 8'h00);
    rc(4'h4, 8'h1F, 8'h10);
    `CHK(intReq, 5'h10)
    `CHK({selectLines13, selectLine0}, 4'hF)
    wr(4'h3, 8'hFA);
    rc(4'h3, 8'hFF, 8'h0A);
    repeat (9) wr(4'h5, 8'h55);
    rc(4'h4, 8'h14, 8'h04);
    `CHK(intReq[2], 1'b1)
    wr(4'h3, 8'h0A);
    rc(4'h4, 8'h14, 8'h10);
    $display("register test done");
    wr(4'h2, 8'h80);
    wr(4'h3, 8'h0E);
    repeat (3) @(negedge mclk);
    `CHK({selectLines13, selectLine0}, 4'hE)
    `CHK({sckOe, mosiOe}, 2'h3)
    wr(4'h5, 8'hA5);
    repeat (3) @(negedge mclk);
    rc(4'h4, 8'hC0, 8'hC0);
    waitq(3);
    rc(4'h6, 8'hFF, 8'h3C);
    `CHK(mRx, 8'hA5)
    repeat (8) @(negedge mclk);
    rc(4'h4, 8'hC8, 8'h00);
    mTx = 8'h12;
    wr(4'h2, 8'h81);
    wr(4'h5, 8'h01);
    wr(4'h5, 8'h02);
    waitq(1);
    `CHK(mRx, 8'h40)
    rc(4'h6, 8'hFF, 8'h48);
    $display("master test done");
    slaveSelIn = 0;
    repeat (8) @(negedge mclk);
    rc(4'h4, 8'h01, 8'h01);
    slaveSelIn = 1;
    repeat (10) @(negedge mclk);
    wr(4'h0, 8'h00);
    rc(4'h4, 8'h01, 8'h00);
    wr(4'h2, 8'h00);
    repeat (4) @(negedge mclk);
    wr(4'h3, 8'h00);
    slaveSelIn = 0;
    #100;
    fork
      sbyte(8'hC3, sr);
      begin #300 wr(4'h5, 8'h5A); end
    join
    `CHK(sr, 8'hFF)
    `CHK(misoOe, 1'b1)
    sbyte(8'h96, sr);
    `CHK(sr, 8'h5A)
    @(negedge mclk) slaveSelIn = 1;
    waitq(3);
    rc(4'h6, 8'hFF, 8'h96);
    $display("slave test done");
    report_and_stop();
  end
endmodule : scsst_top_test
